// ### design/flt_fastlock_ctrl.sv
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Width bit 0: 12-bit denominator, upper ignored
// - Width bit 1: 22-bit denominator, upper joined
// - Codes 0-3: no auto fastlock, GPIO pin
// - Pin: 0 hi-Z, 1 low forced, 2 low, 3 high
// - Codes 4 up: auto fastlock, indicator pin
// - Fastlock lasts twice timeout in reduced-rate sample events
// - Pump gain in fastlock is code plus one
// - Slip code divides sample rate 1,2,4,16
module flt_fastlock_ctrl
  import flt_pkg::*;
(
  input  wire logic        aclk,           // Clock, 25 MHz
  input  wire logic        aresetn,        // Synchronous reset, active low
  input  wire logic        ce,             // Clock enable, freezes state
  input  wire logic        pd_event_pin,   // Comparison event from phase detector
  input  wire logic [7:0]  s_axi_awaddr,   // Write address
  input  wire logic        s_axi_awvalid,  // Write address valid
  output logic             s_axi_awready,  // Write address ready
  input  wire logic [31:0] s_axi_wdata,    // Write data
  input  wire logic [3:0]  s_axi_wstrb,    // Write strobes
  input  wire logic        s_axi_wvalid,   // Write data valid
  output logic             s_axi_wready,   // Write data ready
  output logic [1:0]       s_axi_bresp,    // Write response
  output logic             s_axi_bvalid,   // Write response valid
  input  wire logic        s_axi_bready,   // Write response ready
  input  wire logic [7:0]  s_axi_araddr,   // Read address
  input  wire logic        s_axi_arvalid,  // Read address valid
  output logic             s_axi_arready,  // Read address ready
  output logic [31:0]      s_axi_rdata,    // Read data
  output logic [1:0]       s_axi_rresp,    // Read response
  output logic             s_axi_rvalid,   // Read data valid
  input  wire logic        s_axi_rready,   // Read data ready
  output logic             fastlock_indicator_pin_o,   // Pin level
  output logic             fastlock_indicator_pin_oe,  // Pin drive enable
  output logic [4:0]       pump_gain,      // Charge-pump gain, 0 = steady current
  output logic             fastlock_active,  // Fastlock state flag
  output logic [21:0]      rf_frac_denominator,  // Effective denominator
  output logic [4:0]       sample_factor   // Sample-rate divide factor
);

  // All module state in one struct
  typedef struct packed {
    logic [23:0] word;     // Fastlock control word
    logic [11:0] den_lo;   // Denominator low
    logic [9:0]  den_hi;   // Denominator high
    logic        wide;     // Width select
    logic        aw_got;   // Write address held
    logic        w_got;    // Write data held
    logic [7:0]  awaddr;   // Held write address
    logic [31:0] wdata;    // Held write data
    logic [3:0]  wstrb;    // Held strobes
    logic        bvalid;   // Response pending
    logic [1:0]  bresp;    // Response code
    logic        rvalid;   // Read data pending
    logic [31:0] rdata;    // Read data
    logic [1:0]  rresp;    // Read response code
    flt_state_t  state;    // Fastlock state
    logic [14:0] count;    // Fastlock events remaining
    logic        pin_o;    // Pin level
    logic        pin_oe;   // Pin enable
    logic [4:0]  gain;     // Active pump gain
    logic [21:0] den;      // Registered denominator
    logic [4:0]  factor;   // Registered divide factor
    logic        ev_s1;    // Event synchroniser stage 1
    logic        ev_s2;    // Event synchroniser stage 2
    logic        ev_s3;    // Edge detect history
  } flt_st_t;

  flt_st_t     st_q;       // Registered state
  flt_st_t     st_d;       // Next state
  flt_cfg_t    cfg;        // Decoded word fields
  logic [21:0] den_w;      // Denominator from selector
  logic [4:0]  factor_w;   // Factor from divider
  logic        smp_evt;    // Reduced-rate event
  logic        pd_evt;     // Rising edge of event
  logic        wr_fire;    // Both write halves held
  logic        start_fl;   // Control word write starts fastlock
  logic [31:0] rd_val;     // Read mux
  logic        rd_ok;      // Read address mapped

  // Word fields
  assign cfg.toc = st_q.word[FLT_TOC_LSB +: 14];
  assign cfg.cpf = st_q.word[FLT_CPF_LSB +: 4];
  assign cfg.slip_reduction_code = st_q.word[FLT_CSR_LSB +: 2];
  assign pd_evt  = st_q.ev_s2 && !st_q.ev_s3;

  // Denominator selection
  flt_den_sel u_den (
    .wide   (st_q.wide),
    .den_lo (st_q.den_lo),
    .den_hi (st_q.den_hi),
    .den    (den_w)
  );

  // Slip-reduction sample divider
  flt_slip_div u_slip (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .code    (cfg.slip_reduction_code),
    .pd_evt  (pd_evt),
    .smp_evt (smp_evt),
    .factor  (factor_w)
  );

  // Read mux
  always_comb begin
    rd_ok  = 1'b1;
    rd_val = 32'h00000000;
    case (s_axi_araddr)
      FLT_OFF_CTRL_WORD: rd_val = {8'h00, st_q.word};
      FLT_OFF_DEN_LO:    rd_val = {20'h00000, st_q.den_lo};
      FLT_OFF_DEN_HI:    rd_val = {22'h000000, st_q.den_hi};
      FLT_OFF_MODE:      rd_val = {31'h00000000, st_q.wide};
      FLT_OFF_STATUS:    rd_val = {14'h0000, st_q.count, st_q.state};
      FLT_OFF_DEN_EFF:   rd_val = {10'h000, st_q.den};
      FLT_OFF_PUMP:      rd_val = {22'h000000, st_q.factor, st_q.gain};
      default:           rd_ok  = 1'b0;
    endcase
  end

  assign wr_fire  = st_q.aw_got && st_q.w_got && !st_q.bvalid;
  assign start_fl = wr_fire && (st_q.awaddr == FLT_OFF_CTRL_WORD) && (st_q.wstrb != 4'h0);

  // Next-state logic for bus, fields and fastlock engine
  always_comb begin
    st_d = st_q;
    // Synchronise the event pin
    st_d.ev_s1 = pd_event_pin;
    st_d.ev_s2 = st_q.ev_s1;
    st_d.ev_s3 = st_q.ev_s2;
    // Accept write address and data in either order
    if (s_axi_awvalid && !st_q.aw_got) begin
      st_d.aw_got = 1'b1;
      st_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_q.w_got) begin
      st_d.w_got = 1'b1;
      st_d.wdata = s_axi_wdata;
      st_d.wstrb = s_axi_wstrb;
    end
    // Perform the write with byte strobes
    if (wr_fire) begin
      st_d.aw_got = 1'b0;
      st_d.w_got  = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp  = FLT_RST_BRESP_OK;
      case (st_q.awaddr)
        FLT_OFF_CTRL_WORD: begin
          for (int b = 0; b < 3; b++) begin
            if (st_q.wstrb[b]) begin
              st_d.word[b*8 +: 8] = st_q.wdata[b*8 +: 8];
            end
          end
          st_d.word[3:0] = FLT_SEL_CODE;
        end
        FLT_OFF_DEN_LO: begin
          if (st_q.wstrb[0]) st_d.den_lo[7:0] = st_q.wdata[7:0];
          if (st_q.wstrb[1]) st_d.den_lo[11:8] = st_q.wdata[11:8];
        end
        FLT_OFF_DEN_HI: begin
          if (st_q.wstrb[0]) st_d.den_hi[7:0] = st_q.wdata[7:0];
          if (st_q.wstrb[1]) st_d.den_hi[9:8] = st_q.wdata[9:8];
        end
        FLT_OFF_MODE: begin
          if (st_q.wstrb[0]) st_d.wide = st_q.wdata[0];
        end
        FLT_OFF_STATUS, FLT_OFF_DEN_EFF, FLT_OFF_PUMP: begin
          st_d.bresp = FLT_RESP_SLVERR;  // Read-only
        end
        default: begin
          st_d.bresp = FLT_RESP_SLVERR;  // Unmapped
        end
      endcase
    end
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end
    // Read channel
    if (st_q.rvalid) begin
      if (s_axi_rready) st_d.rvalid = 1'b0;
    end else if (s_axi_arvalid) begin
      st_d.rvalid = 1'b1;
      st_d.rdata  = rd_val;
      st_d.rresp  = rd_ok ? FLT_RST_BRESP_OK : FLT_RESP_SLVERR;
    end
    // Fastlock engine
    case (st_q.state)
      FLT_ST_IDLE: begin
        st_d.gain = 5'h00;
        if (cfg.toc < FLT_TOC_AUTO_MIN) begin
          st_d.state = FLT_ST_MANUAL;
        end else begin
          st_d.pin_oe = 1'b1;
          st_d.pin_o  = 1'b0;
        end
      end
      FLT_ST_FAST: begin
        if (smp_evt) begin
          st_d.count = st_q.count - 15'h0001;
        end
        if (cfg.toc < FLT_TOC_AUTO_MIN) begin
          st_d.state = FLT_ST_MANUAL;
          st_d.count = FLT_RST_COUNT;
        end else if (smp_evt && st_q.count == 15'h0001) begin
          st_d.state = FLT_ST_IDLE;
          st_d.gain  = 5'h00;
          st_d.pin_o = 1'b0;
        end
      end
      FLT_ST_MANUAL: begin
        st_d.pin_oe = (cfg.toc != FLT_TOC_HIZ);
        st_d.pin_o  = (cfg.toc == FLT_TOC_HIGH);
        st_d.gain   = (cfg.toc == FLT_TOC_FORCE) ? {1'b0, cfg.cpf} + 5'h01 : 5'h00;
        if (cfg.toc >= FLT_TOC_AUTO_MIN) begin
          st_d.state = FLT_ST_IDLE;
        end
      end
      default: begin
        st_d.state = FLT_ST_IDLE;
      end
    endcase
    // A new control word write with timeout code 4 or up launches an automatic fastlock period
    if (start_fl && (st_d.word[FLT_TOC_LSB +: 14] >= FLT_TOC_AUTO_MIN)) begin
      st_d.state  = FLT_ST_FAST;
      st_d.count  = {st_d.word[FLT_TOC_LSB +: 14], 1'b0};
      st_d.gain   = {1'b0, st_d.word[FLT_CPF_LSB +: 4]} + 5'h01;
      st_d.pin_oe = 1'b1;
      st_d.pin_o  = 1'b1;
    end
    st_d.den    = den_w;
    st_d.factor = factor_w;
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q        <= '0;
      st_q.word   <= FLT_RST_CTRL_WORD;
      st_q.den_lo <= FLT_RST_DEN_LO;
      st_q.den_hi <= FLT_RST_DEN_HI;
      st_q.state  <= FLT_ST_IDLE;
      st_q.count  <= FLT_RST_COUNT;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  // Outputs from flip-flops
  assign s_axi_awready             = !st_q.aw_got;
  assign s_axi_wready              = !st_q.w_got;
  assign s_axi_bvalid              = st_q.bvalid;
  assign s_axi_bresp               = st_q.bresp;
  assign s_axi_arready             = !st_q.rvalid;
  assign s_axi_rvalid              = st_q.rvalid;
  assign s_axi_rdata               = st_q.rdata;
  assign s_axi_rresp               = st_q.rresp;
  assign fastlock_indicator_pin_o  = st_q.pin_o;
  assign fastlock_indicator_pin_oe = st_q.pin_oe;
  assign pump_gain                 = st_q.gain;
  assign fastlock_active           = (st_q.state == FLT_ST_FAST);
  assign rf_frac_denominator       = st_q.den;
  assign sample_factor             = st_q.factor;

  // Checks
  a_den_narrow: assert property (@(posedge aclk) disable iff (!aresetn)
    (!st_q.wide && ce) |=> (st_q.den[21:12] == 10'h000)) else $error("upper bits used");
  a_den_wide: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_q.wide && ce) |=>
    (st_q.den == {$past(st_q.den_hi), $past(st_q.den_lo)})) else $error("wide denominator wrong");
  a_sel_code: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q.word[3:0] == FLT_SEL_CODE) else $error("select code lost");
  a_manual_off: assert property (@(posedge aclk) disable iff (!aresetn)
    (cfg.toc < FLT_TOC_AUTO_MIN && st_q.state == FLT_ST_FAST && ce) |=>
    (st_q.state == FLT_ST_MANUAL)) else $error("fastlock kept in manual");
  a_pin_hiz: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_q.state == FLT_ST_MANUAL && cfg.toc == FLT_TOC_HIZ && ce && !start_fl && $stable(st_q.word)) |=>
    !fastlock_indicator_pin_oe) else $error("pin driven at code 0");
  a_pin_high: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_q.state == FLT_ST_MANUAL && cfg.toc == FLT_TOC_HIGH && ce && !start_fl && $stable(st_q.word)) |=>
    (fastlock_indicator_pin_oe && fastlock_indicator_pin_o)) else $error("pin not high");
  a_auto_start: assert property (@(posedge aclk) disable iff (!aresetn)
    (start_fl && ce && st_d.word[FLT_TOC_LSB +: 14] >= FLT_TOC_AUTO_MIN) |=>
    (fastlock_active && fastlock_indicator_pin_o && st_q.count == {cfg.toc, 1'b0}))
    else $error("fastlock not started");
  a_gain_fast: assert property (@(posedge aclk) disable iff (!aresetn)
    fastlock_active |-> (pump_gain == {1'b0, cfg.cpf} + 5'h01)) else $error("fastlock gain wrong");
  a_end_steady: assert property (@(posedge aclk) disable iff (!aresetn)
    (fastlock_active && smp_evt && st_q.count == 15'h0001 && ce && !start_fl) |=>
    (!fastlock_active && pump_gain == 5'h00 && !fastlock_indicator_pin_o)) else $error("bad end");
  a_count_evt: assert property (@(posedge aclk) disable iff (!aresetn)
    (fastlock_active && !smp_evt && ce && !start_fl && cfg.toc >= FLT_TOC_AUTO_MIN) |=>
    $stable(st_q.count)) else $error("count moved without event");

endmodule : flt_fastlock_ctrl
`default_nettype wire

// ### design/flt_pkg.sv
package flt_pkg;

  // Register byte offsets on the AXI4-Lite bus
  localparam logic [7:0]  FLT_OFF_CTRL_WORD  = 8'h00;  // Fastlock control word (24 bits)
  localparam logic [7:0]  FLT_OFF_DEN_LO     = 8'h04;  // Denominator low 12 bits
  localparam logic [7:0]  FLT_OFF_DEN_HI     = 8'h08;  // Denominator high 10 bits
  localparam logic [7:0]  FLT_OFF_MODE       = 8'h0C;  // Width select
  localparam logic [7:0]  FLT_OFF_STATUS     = 8'h10;  // Block state readback
  localparam logic [7:0]  FLT_OFF_DEN_EFF    = 8'h14;  // Effective denominator
  localparam logic [7:0]  FLT_OFF_PUMP       = 8'h18;  // Active pump gain and sample divide

  // Control word field positions
  localparam int          FLT_SEL_LSB        = 0;
  localparam int          FLT_TOC_LSB        = 4;
  localparam int          FLT_CPF_LSB        = 18;
  localparam int          FLT_CSR_LSB        = 22;
  localparam logic [3:0]  FLT_SEL_CODE       = 4'hD;   // Select code 1101

  // Timeout code meanings
  localparam logic [13:0] FLT_TOC_HIZ        = 14'h0000;
  localparam logic [13:0] FLT_TOC_FORCE      = 14'h0001;
  localparam logic [13:0] FLT_TOC_LOW        = 14'h0002;
  localparam logic [13:0] FLT_TOC_HIGH       = 14'h0003;
  localparam logic [13:0] FLT_TOC_AUTO_MIN   = 14'h0004;

  // Values after reset and bus response codes
  localparam logic [23:0] FLT_RST_CTRL_WORD  = 24'h00000D;
  localparam logic [11:0] FLT_RST_DEN_LO     = 12'h000;
  localparam logic [9:0]  FLT_RST_DEN_HI     = 10'h000;
  localparam logic [1:0]  FLT_RST_BRESP_OK   = 2'h0;
  localparam logic [1:0]  FLT_RESP_SLVERR    = 2'h2;
  localparam logic [14:0] FLT_RST_COUNT      = 15'h0000;
  localparam logic [3:0]  FLT_RST_SLIP_CNT   = 4'h0;

  // Fastlock state machine
  typedef enum logic [2:0] {
    FLT_ST_IDLE   = 3'b001,  // Steady state
    FLT_ST_FAST   = 3'b010,  // Counting fastlock period
    FLT_ST_MANUAL = 3'b100   // Manual or general-purpose pin
  } flt_state_t;

  // Decoded configuration carried to the fastlock engine
  typedef struct packed {
    logic [13:0] toc;    // Timeout count
    logic [3:0]  cpf;    // Fastlock pump code
    logic [1:0]  slip_reduction_code;    // Slip-reduction code
  } flt_cfg_t;

  // Pin driver pair
  typedef struct packed {
    logic o;   // Output level
    logic oe;  // Output enable, high while driving
  } flt_pin_t;

endpackage : flt_pkg

// ### design/flt_slip_div.sv
`timescale 1ns/1ps
`default_nettype none
module flt_slip_div
  import flt_pkg::*;
(
  input  wire logic       aclk,     // System clock
  input  wire logic       aresetn,  // Synchronous reset, active low
  input  wire logic       ce,       // Clock enable
  input  wire logic [1:0] code,     // Slip-reduction code
  input  wire logic       pd_evt,   // Comparison event pulse
  output logic            smp_evt,  // Reduced-rate sample pulse
  output logic [4:0]      factor    // Divide factor 1/2/4/16
);

  // All state of the divider
  typedef struct packed {
    logic [3:0] cnt;  // Event counter
  } flt_div_st_t;

  flt_div_st_t st_q;  // Registered state
  flt_div_st_t st_d;  // Next state
  logic [3:0]  mask;  // Counter wrap mask

  // Factor and wrap mask per code
  always_comb begin
    case (code)
      2'h0: begin
        factor = 5'h01;
        mask   = 4'h0;
      end
      2'h1: begin
        factor = 5'h02;
        mask   = 4'h1;
      end
      2'h2: begin
        factor = 5'h04;
        mask   = 4'h3;
      end
      default: begin
        factor = 5'h10;
        mask   = 4'hF;
      end
    endcase
  end

  // Count events, pass one per factor
  always_comb begin
    st_d = st_q;
    if (pd_evt) begin
      st_d.cnt = (st_q.cnt + 4'h1) & mask;
    end
  end

  assign smp_evt = pd_evt && ((st_q.cnt & mask) == mask);

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q.cnt <= FLT_RST_SLIP_CNT;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  // One sample every event when disabled
  a_slip_off_pass: assert property (@(posedge aclk) disable iff (!aresetn)
    (code == 2'h0 && pd_evt) |-> smp_evt) else $error("slip off lost event");

endmodule : flt_slip_div
`default_nettype wire

// ### design/flt_den_sel.sv
`timescale 1ns/1ps
`default_nettype none
module flt_den_sel
  import flt_pkg::*;
(
  input  wire logic        wide,    // Width select, 1 = 22-bit
  input  wire logic [11:0] den_lo,  // Low denominator bits
  input  wire logic [9:0]  den_hi,  // High denominator bits
  output logic [21:0]      den      // Effective denominator
);

  // Upper bits ignored in 12-bit mode
  always_comb begin
    if (wide) begin
      den = {den_hi, den_lo};
    end else begin
      den = {10'h000, den_lo};
    end
  end

endmodule : flt_den_sel
`default_nettype wire

// ### test/flt_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module flt_host_model
  import flt_pkg::*;
(
  input  wire logic        aclk,      // System clock
  output logic [7:0]       awaddr,    // Write address
  output logic             awvalid,   // Write address valid
  input  wire logic        awready,   // Write address ready
  output logic [31:0]      wdata,     // Write data
  output logic [3:0]       wstrb,     // Write strobes
  output logic             wvalid,    // Write data valid
  input  wire logic        wready,    // Write data ready
  input  wire logic [1:0]  bresp,     // Write response
  input  wire logic        bvalid,    // Write response valid
  output logic             bready,    // Write response ready
  output logic [7:0]       araddr,    // Read address
  output logic             arvalid,   // Read address valid
  input  wire logic        arready,   // Read address ready
  input  wire logic [31:0] rdata,     // Read data
  input  wire logic [1:0]  rresp,     // Read response
  input  wire logic        rvalid,    // Read data valid
  output logic             rready,    // Read data ready
  output logic             pd_evt     // Comparison event line
);
  // Idle bus and quiet event line at time zero
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready, pd_evt}               = '0;
  end

  // Builds a control word with the select code in the low nibble
  function automatic logic [31:0] make_word(input logic [13:0] toc, input logic [3:0] cpf,
                                            input logic [1:0] slip_reduction_code);
    return {8'h00, slip_reduction_code, cpf, toc, FLT_SEL_CODE};
  endfunction : make_word

  // One write; address and data released each when taken
  task automatic write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask : write

  // One read; data taken at the edge where rvalid is seen
  task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : read

  // Denominator split; small values leave the upper part at zero
  task automatic set_den(input logic [21:0] v, input logic wide, output logic [1:0] r);
    write(FLT_OFF_DEN_LO, {20'h00000, v[11:0]}, r);
    write(FLT_OFF_DEN_HI, {22'h000000, (v < 22'h001000) ? 10'h000 : v[21:12]}, r);
    write(FLT_OFF_MODE, {31'h00000000, wide}, r);
  endtask : set_den

  // Single-cycle events with three low cycles between them
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge aclk);
      pd_evt <= 1'b1;
      @(posedge aclk);
      pd_evt <= 1'b0;
      repeat (2) @(posedge aclk);
    end
  endtask : pulse
endmodule : flt_host_model
`default_nettype wire

// ### test/fastlock_timeout_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module fastlock_timeout_control_bench
  import flt_pkg::*;
;
  logic        aclk, aresetn, ce, pd_evt;              // Clock, reset, enable, events
  logic [7:0]  awaddr, araddr;                         // Bus addresses
  logic        awvalid, awready, wvalid, wready;       // Write handshakes
  logic        bvalid, bready, arvalid, arready;       // Response and read handshakes
  logic        rvalid, rready;                         // Read data handshake
  logic [31:0] wdata, rdata, rd;                       // Bus data
  logic [3:0]  wstrb;                                  // Write strobes
  logic [1:0]  bresp, rresp, resp;                     // Responses
  logic        pin_o, pin_oe, active;                  // Pin and state
  logic [4:0]  gain, factor;                           // Pump gain, sample divide
  logic [21:0] den;                                    // Effective denominator
  int          mismatches, n_checks, cycles;           // Bookkeeping
  localparam logic [4:0] FAC [4] = '{5'h01, 5'h02, 5'h04, 5'h10};  // Divide per slip code

  flt_host_model host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .pd_evt(pd_evt));

  flt_fastlock_ctrl dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .pd_event_pin(pd_evt),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .fastlock_indicator_pin_o(pin_o), .fastlock_indicator_pin_oe(pin_oe),
    .pump_gain(gain), .fastlock_active(active), .rf_frac_denominator(den), .sample_factor(factor));

  // Clock at 25 MHz
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // Compares and counts; reports a mismatch at once
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  // Hang guard
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      summarize();
    end
  end

  // Two-cycle reset, clears divider phase between runs
  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : do_reset

  // Automatic fastlock run counted in reduced-rate events
  task automatic auto_run(input logic [13:0] toc, input logic [3:0] cpf, input logic [1:0] slip_reduction_code);
    do_reset();
    host.write(FLT_OFF_CTRL_WORD, host.make_word(toc, cpf, slip_reduction_code), resp);
    check({30'h0, resp}, 32'h0);
    repeat (2) @(posedge aclk);
    check({30'h0, pin_oe, pin_o}, 32'h3);
    check({27'h0, gain}, {27'h0, 5'({1'b0, cpf} + 5'h01)});
    check({27'h0, factor}, {27'h0, FAC[slip_reduction_code]});
    host.read(FLT_OFF_PUMP, rd, resp);
    check(rd, {22'h0, FAC[slip_reduction_code], 5'({1'b0, cpf} + 5'h01)});
    host.pulse(2 * int'(toc) * int'(FAC[slip_reduction_code]) - 1);
    repeat (6) @(posedge aclk);
    check({31'h0, active}, 32'h1);
    host.pulse(1);
    repeat (6) @(posedge aclk);
    check({31'h0, active}, 32'h0);
    check({25'h0, pin_oe, pin_o, gain}, 32'h40);
  endtask : auto_run

  // Main sequence
  initial begin
    aresetn = 1'b0;
    ce      = 1'b1;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values and refused accesses
    host.read(FLT_OFF_DEN_LO, rd, resp);
    check(rd, 32'h0);
    host.read(FLT_OFF_STATUS, rd, resp);
    check(rd, 32'h4);
    host.read(8'h1C, rd, resp);
    check({rd[29:0], resp}, {30'h0, FLT_RESP_SLVERR});
    host.write(FLT_OFF_STATUS, 32'hFFFFFFFF, resp);
    check({30'h0, resp}, {30'h0, FLT_RESP_SLVERR});
    // Denominator width selection
    host.write(FLT_OFF_DEN_LO, 32'h00000ABC, resp);
    host.write(FLT_OFF_DEN_HI, 32'h000003FF, resp);
    host.write(FLT_OFF_MODE, 32'h0, resp);
    repeat (2) @(posedge aclk);
    check({10'h0, den}, 32'h00000ABC);
    host.write(FLT_OFF_MODE, 32'h1, resp);
    host.read(FLT_OFF_DEN_EFF, rd, resp);
    check(rd, 32'h003FFABC);
    host.set_den(22'h000064, 1'b1, resp);
    repeat (2) @(posedge aclk);
    check({10'h0, den}, 32'h00000064);
    // Manual pin codes
    for (int c = 0; c < 4; c++) begin
      host.write(FLT_OFF_CTRL_WORD, host.make_word(14'(c), 4'h5, 2'h0), resp);
      repeat (3) @(posedge aclk);
      check({30'h0, pin_oe, pin_o}, {30'h0, c != 0, c == 3});
      check({31'h0, active}, 32'h0);
      check({27'h0, gain}, (c == 1) ? 32'h6 : 32'h0);
    end
    // Forced fastlock across every pump code
    for (int p = 0; p < 16; p++) begin
      host.write(FLT_OFF_CTRL_WORD, host.make_word(14'h0001, 4'(p), 2'h0), resp);
      repeat (3) @(posedge aclk);
      check({27'h0, gain}, 32'(p + 1));
    end
    // Select nibble written as zero is still accepted as this word
    host.write(FLT_OFF_CTRL_WORD, 32'h00000030, resp);
    repeat (3) @(posedge aclk);
    check({30'h0, pin_oe, pin_o}, 32'h3);
    host.read(FLT_OFF_CTRL_WORD, rd, resp);
    check(rd, 32'h0000003D);
    // Automatic runs over every slip code
    for (int s = 0; s < 4; s++) auto_run(14'h0004, 4'(7 + s), 2'(s));
    auto_run(14'h0005, 4'hF, 2'h0);
    // Events while the clock enable is low are not counted
    host.write(FLT_OFF_CTRL_WORD, host.make_word(14'h0004, 4'h0, 2'h0), resp);
    ce <= 1'b0;
    host.pulse(3);
    ce <= 1'b1;
    host.read(FLT_OFF_STATUS, rd, resp);
    check(rd, 32'h00000042);
    summarize();
  end
endmodule : fastlock_timeout_control_bench
`default_nettype wire
